// ==== logic/ssh_defs.vh ====
// Constants for the graceful halt handler of the stepping position controller.
// Assumes it is included by bare name from the design file.
`ifndef SSH_DEFS_VH
`define SSH_DEFS_VH
`define SSH_ADDR_TOP      2'h3
`define SSH_ADDR_LSB      1'h0
`define SSH_CMD_HALT      8'h8F
`define SSH_POS_W         16
`define SSH_VEL_W         4
`define SSH_ST_IDLE       2'h0
`define SSH_ST_RUN        2'h1
`define SSH_ST_DECEL      2'h2
`define SSH_ST_LOAD       2'h3
`endif

// ==== logic/ssh_soft_stop_handler.v ====
// Graceful halt handler: frame decoder, thermal trigger, deceleration and position hold.
// Assumes the I2C front end delivers received bytes as one-cycle strobes, synchronous to CLOCK.
`timescale 1ns/1ps
`include "ssh_defs.vh"

module ssh_soft_stop_handler #(
  parameter POS_W = `SSH_POS_W,
  parameter VEL_W = `SSH_VEL_W
) (
  input  wire                    CLOCK,
  input  wire                    RST_B,
  input  wire [3:0]              PROGRAMMED_ADDRESS,
  input  wire                    HARDWIRED_ADDRESS_BIT,
  input  wire                    BYTE_VALID,
  input  wire                    BYTE_FIRST,
  input  wire [7:0]              BYTE_DATA,
  input  wire                    FRAME_END,
  input  wire                    THERMAL_SHUTDOWN,
  input  wire                    MOTION_ACTIVE,
  input  wire [VEL_W-1:0]        VELOCITY,
  input  wire [VEL_W-1:0]        MIN_VELOCITY,
  input  wire signed [POS_W-1:0] ACTUAL_POSITION,
  input  wire                    TARGET_LOAD,
  input  wire signed [POS_W-1:0] TARGET_IN,
  output reg  signed [POS_W-1:0] TARGET_POSITION,
  output reg                     DECEL_REQUEST,
  output reg                     HALT_REQUEST,
  output reg                     HALT_BUSY,
  output reg                     GRACEFUL_HALT_COMMAND
);

  // Control sequence state and its next value.
  reg  [1:0]             state;
  reg  [1:0]             next_state;

  // Progress through the two-byte frame.
  reg                    addr_match;
  reg                    next_addr_match;
  reg                    cmd_seen;
  reg                    next_cmd_seen;

  // Thermal level of the previous cycle, for the edge detector.
  reg                    thermal_prev;

  // Next values of the registered outputs.
  reg                    next_decel_request;
  reg                    next_halt_request;
  reg                    next_halt_busy;
  reg signed [POS_W-1:0] next_target_position;

  // Byte comparison, one flag per bit.
  wire [7:0]             own_addr;
  wire [7:0]             halt_code;
  wire [7:0]             addr_bit_eq;
  wire [7:0]             cmd_bit_eq;
  wire                   addr_hit;
  wire                   cmd_hit;

  // Halt sources.
  wire                   bus_halt;
  wire                   thermal_halt;
  wire                   halt_event;

  genvar                 bit_idx;

  assign own_addr = {`SSH_ADDR_TOP, PROGRAMMED_ADDRESS, HARDWIRED_ADDRESS_BIT,
                     `SSH_ADDR_LSB};
  assign halt_code = `SSH_CMD_HALT;

  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_byte_cmp
      assign addr_bit_eq[bit_idx] = (BYTE_DATA[bit_idx] == own_addr[bit_idx]);
      assign cmd_bit_eq[bit_idx]  = (BYTE_DATA[bit_idx] == halt_code[bit_idx]);
    end
  endgenerate

  assign addr_hit = &addr_bit_eq;
  assign cmd_hit  = &cmd_bit_eq;

  // The command acts only when the frame closes after exactly two bytes, so a
  // longer frame starting with the same code is not mistaken for a halt.
  always @* begin
    next_addr_match = addr_match;
    next_cmd_seen   = cmd_seen;
    if (BYTE_VALID && BYTE_FIRST) begin
      next_addr_match = addr_hit;
      next_cmd_seen   = 1'b0;
    end else if (BYTE_VALID) begin
      next_addr_match = 1'b0;
      next_cmd_seen   = addr_match && !cmd_seen && cmd_hit;
    end else if (FRAME_END) begin
      next_addr_match = 1'b0;
      next_cmd_seen   = 1'b0;
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_B) begin
      addr_match <= 1'b0;
      cmd_seen   <= 1'b0;
    end else begin
      addr_match <= next_addr_match;
      cmd_seen   <= next_cmd_seen;
    end
  end

  // The thermal source is edge triggered, so a temperature that stays high
  // does not restart the halt over and over once the motor is stopped.
  always @(posedge CLOCK) begin
    if (!RST_B) begin
      thermal_prev <= 1'b0;
    end else begin
      thermal_prev <= THERMAL_SHUTDOWN;
    end
  end

  assign bus_halt     = FRAME_END && cmd_seen;
  assign thermal_halt = THERMAL_SHUTDOWN && !thermal_prev;
  assign halt_event   = bus_halt || thermal_halt;

  // A new halt during an ongoing halt is absorbed: the sequence already heads
  // to a stop, and restarting it would only delay the position hold.
  always @* begin
    next_state = state;
    case (state)
      `SSH_ST_IDLE: begin
        if (halt_event && MOTION_ACTIVE) begin
          next_state = `SSH_ST_DECEL;
        end else if (halt_event) begin
          next_state = `SSH_ST_LOAD;
        end
      end
      `SSH_ST_DECEL: begin
        if (!MOTION_ACTIVE || VELOCITY <= MIN_VELOCITY) begin
          next_state = `SSH_ST_RUN;
        end
      end
      `SSH_ST_RUN: begin
        if (!MOTION_ACTIVE) begin
          next_state = `SSH_ST_LOAD;
        end
      end
      `SSH_ST_LOAD: begin
        next_state = `SSH_ST_IDLE;
      end
      default: begin
        next_state = `SSH_ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RST_B) begin
      state <= `SSH_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The motion requests follow the next state, so the motion core sees them
  // in the same cycle as the state that they belong to.
  always @* begin
    next_decel_request = 1'b0;
    next_halt_request  = 1'b0;
    next_halt_busy     = 1'b1;
    case (next_state)
      `SSH_ST_IDLE: begin
        next_halt_busy = 1'b0;
      end
      `SSH_ST_DECEL: begin
        next_decel_request = 1'b1;
      end
      `SSH_ST_RUN: begin
        next_halt_request = 1'b1;
      end
      `SSH_ST_LOAD: begin
        next_halt_busy = 1'b1;
      end
      default: begin
        next_halt_busy = 1'b0;
      end
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RST_B) begin
      DECEL_REQUEST <= 1'b0;
      HALT_REQUEST  <= 1'b0;
      HALT_BUSY     <= 1'b0;
    end else begin
      DECEL_REQUEST <= next_decel_request;
      HALT_REQUEST  <= next_halt_request;
      HALT_BUSY     <= next_halt_busy;
    end
  end

  // The pulse shows every accepted halt, also one absorbed by a running
  // sequence, so the host side can count what it sent.
  always @(posedge CLOCK) begin
    if (!RST_B) begin
      GRACEFUL_HALT_COMMAND <= 1'b0;
    end else begin
      GRACEFUL_HALT_COMMAND <= halt_event;
    end
  end

  // A normal target load is refused while a halt runs or starts, so the held
  // stop position cannot be overwritten behind the sequence's back.
  always @* begin
    next_target_position = TARGET_POSITION;
    if (state == `SSH_ST_LOAD) begin
      next_target_position = ACTUAL_POSITION;
    end else if (TARGET_LOAD && state == `SSH_ST_IDLE && !halt_event) begin
      next_target_position = TARGET_IN;
    end
  end

  always @(posedge CLOCK) begin
    if (!RST_B) begin
      TARGET_POSITION <= {POS_W{1'b0}};
    end else begin
      TARGET_POSITION <= next_target_position;
    end
  end

endmodule

// ==== testbench/ssh_host.sv ====
`timescale 1ns/1ps
// Bus front end model; called at a falling edge, gives each byte as a strobe.
module ssh_host(input wire CLOCK,output reg BYTE_VALID=0,BYTE_FIRST=0,FRAME_END=0,
  output reg [7:0] BYTE_DATA=0);
  task send(input [7:0] a,c);
    {BYTE_VALID,BYTE_FIRST,BYTE_DATA}={2'b11,a}; @(negedge CLOCK);
    {BYTE_FIRST,BYTE_DATA}={1'b0,c}; @(negedge CLOCK);
    {BYTE_VALID,BYTE_DATA,FRAME_END}={1'b0,~c,1'b1}; @(negedge CLOCK);
    FRAME_END=0;
  endtask
endmodule

// ==== testbench/ssh_properties.sv ====
`timescale 1ns/1ps
// Port checks of the halt handler; assumes one clock and a synchronous low reset.
module ssh_properties(input wire CLOCK,RST_B,THERMAL_SHUTDOWN,MOTION_ACTIVE,DECEL_REQUEST,
  HALT_REQUEST,HALT_BUSY,GRACEFUL_HALT_COMMAND,input wire [3:0] VELOCITY,MIN_VELOCITY,
  input wire signed [15:0] ACTUAL_POSITION,TARGET_POSITION);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  property p_heat; $rose(THERMAL_SHUTDOWN)|=>GRACEFUL_HALT_COMMAND; endproperty
  a_heat: assert property(p_heat) else $error("heat");
  property p_slow; DECEL_REQUEST&&VELOCITY<=MIN_VELOCITY|=>HALT_REQUEST&&!DECEL_REQUEST; endproperty
  a_slow: assert property(p_slow) else $error("slow");
  property p_stop; HALT_REQUEST&&!MOTION_ACTIVE|=>!HALT_REQUEST##1!HALT_BUSY; endproperty
  a_stop: assert property(p_stop) else $error("stop");
  property p_busy; DECEL_REQUEST||HALT_REQUEST|->HALT_BUSY; endproperty
  a_busy: assert property(p_busy) else $error("busy");
  property p_hold; $fell(HALT_BUSY)|->TARGET_POSITION==$past(ACTUAL_POSITION); endproperty
  a_hold: assert property(p_hold) else $error("hold");
  property p_cmd; GRACEFUL_HALT_COMMAND|->HALT_BUSY; endproperty
  a_cmd: assert property(p_cmd) else $error("cmd");
  property p_still; $rose(HALT_BUSY)&&!DECEL_REQUEST|=>!HALT_BUSY; endproperty
  a_still: assert property(p_still) else $error("still");
  c_heat: cover property($rose(THERMAL_SHUTDOWN));
  c_stop: cover property(HALT_REQUEST&&!MOTION_ACTIVE);
  c_still: cover property($rose(HALT_BUSY)&&!DECEL_REQUEST);
endmodule
bind ssh_soft_stop_handler ssh_properties i_props(.*);

// ==== testbench/test_soft_stop_handler.sv ====
`timescale 1ns/1ps
// Random frames and a thermal halt; the host model gives the byte strobes.
module test_soft_stop_handler;
  reg CLOCK=0,RST_B=0,THERMAL_SHUTDOWN=0,MOTION_ACTIVE=0,TARGET_LOAD=0,HARDWIRED_ADDRESS_BIT=0;
  reg [3:0] PROGRAMMED_ADDRESS=0,VELOCITY=5,MIN_VELOCITY=2;
  reg signed [15:0] ACTUAL_POSITION=0,TARGET_IN=0,lf=16'h80FB;
  wire signed [15:0] TARGET_POSITION;
  wire [7:0] BYTE_DATA,ad={2'b11,PROGRAMMED_ADDRESS,HARDWIRED_ADDRESS_BIT,1'b0};
  wire BYTE_VALID,BYTE_FIRST,FRAME_END,DECEL_REQUEST,HALT_REQUEST,HALT_BUSY,GRACEFUL_HALT_COMMAND;
  integer num_errors=0,checks_done=0,n=0,i;
  ssh_host i_host(.*);
  ssh_soft_stop_handler i_dut(.*);
  always @(posedge CLOCK) n<=n+GRACEFUL_HALT_COMMAND;
  initial forever #2.5 CLOCK=~CLOCK;
  task s(input integer k); repeat(k) @(negedge CLOCK); endtask
  task chk(input [16:0] g,e); checks_done++;
    if(g!==e) begin num_errors++; $display("MISMATCH %0t %h %h",$time,g,e); end
  endtask
  task conclude; $display("errors %0d checks %0d",num_errors,checks_done);
    if(num_errors==0&&checks_done>0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    s(16); RST_B=1; s(1);
    for(i=0;i<4;i++) begin
      lf={lf[14:0],lf[15]^lf[13]^lf[12]^lf[10]}; {PROGRAMMED_ADDRESS,HARDWIRED_ADDRESS_BIT}=lf[4:0];
      TARGET_IN=lf; TARGET_LOAD=1; s(1); TARGET_LOAD=0; ACTUAL_POSITION=~lf; s(1);
      chk(TARGET_POSITION,TARGET_IN);
      i_host.send(ad^8'h02,8'h8F); s(3); chk(TARGET_POSITION,TARGET_IN);
      i_host.send(ad,lf[7:0]|8'h40); s(3); chk(TARGET_POSITION,TARGET_IN);
      i_host.send(ad,8'h8F); s(3); chk(TARGET_POSITION,ACTUAL_POSITION);
    end
    MOTION_ACTIVE=1; THERMAL_SHUTDOWN=1; s(3);
    chk({HALT_BUSY,DECEL_REQUEST,HALT_REQUEST},3'b110);
    VELOCITY=2; s(2); chk({DECEL_REQUEST,HALT_REQUEST},2'b01);
    i_host.send(ad,8'h8F); MOTION_ACTIVE=0; s(3);
    chk({HALT_BUSY,TARGET_POSITION},{1'b0,ACTUAL_POSITION});
    chk(n,6);
    conclude;
  end
endmodule
